// file: hw/pmc_pkg.sv
// Constants and types for the performance monitor counters
package pmc_pkg;
  localparam int unsigned pmc_num_ctr = 4;
  localparam int unsigned pmc_evt_w = 6;
  localparam logic [5:0] pmc_evt_max = 6'h29;
  localparam logic [11:0] pmc_addr_gpmc = 12'h7d0;
  localparam logic [11:0] pmc_addr_cnt_lo = 12'hb03;
  localparam logic [11:0] pmc_addr_cnt_hi = 12'hb83;
  localparam logic [11:0] pmc_addr_evt = 12'h323;
  localparam logic [11:0] pmc_addr_hpm_last = 12'h01f;
  localparam logic pmc_gpmc_reset = 1'b1;
  localparam logic [63:0] pmc_cnt_reset = 64'h0;
  localparam logic [5:0] pmc_evt_reset = 6'h00;

  // Event indications from core, one bundle per cycle
  typedef struct packed {
    logic icache_hit;
    logic icache_miss;
    logic [1:0] commit_all;
    logic [1:0] commit_16b;
    logic [1:0] commit_32b;
    logic [1:0] aligned;
    logic [1:0] decoded;
    logic mul;
    logic div;
    logic load;
    logic store;
    logic misal_load;
    logic misal_store;
    logic [1:0] alu;
    logic csr_read;
    logic csr_rw;
    logic csr_write_rd0;
    logic ebreak;
    logic ecall;
    logic fence;
    logic fence_i;
    logic mret;
    logic br_commit;
    logic br_mispredict;
    logic br_taken;
    logic br_unpredict;
    logic stall_fetch;
    logic stall_aligner;
    logic stall_decode;
    logic stall_postsync;
    logic stall_presync;
    logic loadstore_pipe_freeze;
    logic store_and_write_buffers_full;
    logic stall_dma_data;
    logic stall_dma_instr;
    logic exception;
    logic timer_int;
    logic ext_int;
    logic trap_logic_unit_flush;
    logic br_error_flush;
  } pmc_events_t;

  // CSR access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pmc_csr_req_t;

  typedef struct packed {
    logic gpmc_en;
    logic [3:0][63:0] cnt;
    logic [3:0][5:0] evt;
    logic [31:0] rdata;
  } pmc_state_t;
endpackage

// file: hw/pmc_unit.sv
// Performance monitor counters with group enable and event decode
`timescale 1ns/1ns
// Operation
// R1 - Group enable bit 0 at 0x7d0 gates all four counters, resets to 1
// R2 - Group enable only gates increments, never alters counter values
// R3 - Group enable register bits 31:1 always read zero
// R4 - Writable registers accept any value, read back only legal values
// R5 - Counters 3 to 6 work, each counting its own selected event
// R6 - Counters and selectors 7 to 31 read zero, writes ignored
// R7 - Power-management halt stops all counters, cycle counter included
// R8 - In debug halt, stopcount decides whether counters run
// R9 - DMA in halt with counting stopped is not counted
// R10 - Pause instruction keeps counters running
// R11 - Read returns value before increment; increment applies before a write
// R12 - Software should disable group before modifying counters or selectors
// R13 - Selector write above highest event stores highest event
// R14 - Event 0 counts nothing; event 1 counts active clock cycles
// R15 - Events 2,3 count instruction cache hits and misses
// R16 - Events 4-6 count committed instructions all, 16-bit, 32-bit
// R17 - Events 7,8 count aligned and decoded instructions
// R18 - Events 9-14 count mul, div, loads, stores, misaligned loads/stores
// R19 - Events 15-23 count ALU, CSR classes, ebreak, ecall, fences, mret
// R20 - Events 24-27 count branch commit, mispredict, taken, unpredictable
// R21 - Events 28-36 count the stall cycle classes
// R22 - Events 37-41 count exceptions, interrupts, and flushes
// R23 - Each counter is 64 bits, read as low and high halves
// R24 - Permitted cycles add zero to two occurrences to the counter
module pmc_unit (
  input wire logic clock,
  input wire logic arst_n,
  input wire pmc_pkg::pmc_csr_req_t csr_req,
  output logic [31:0] csr_rdata,
  output logic csr_hit,
  input wire pmc_pkg::pmc_events_t events,
  input wire logic power_mgmt_halt_state,
  input wire logic debug_halted_state,
  input wire logic dbg_stopcount,
  input wire logic pause_active,
  output logic count_permitted
);
  import pmc_pkg::*;

  pmc_state_t st;
  pmc_state_t next_st;
  logic [3:0][1:0] inc;
  logic run;

  function automatic logic [1:0] evt_count(input logic [5:0] code, input pmc_events_t e);
    logic [1:0] n;
    n = 2'h0;
    unique case (code)
      6'd0: n = 2'h0; // [R14]
      6'd1: n = 2'h1; // [R14]
      6'd2: n = {1'b0, e.icache_hit}; // [R15]
      6'd3: n = {1'b0, e.icache_miss}; // [R15]
      6'd4: n = e.commit_all; // [R16]
      6'd5: n = e.commit_16b; // [R16]
      6'd6: n = e.commit_32b; // [R16]
      6'd7: n = e.aligned; // [R17]
      6'd8: n = e.decoded; // [R17]
      6'd9: n = {1'b0, e.mul}; // [R18]
      6'd10: n = {1'b0, e.div}; // [R18]
      6'd11: n = {1'b0, e.load}; // [R18]
      6'd12: n = {1'b0, e.store}; // [R18]
      6'd13: n = {1'b0, e.misal_load}; // [R18]
      6'd14: n = {1'b0, e.misal_store}; // [R18]
      6'd15: n = e.alu; // [R19]
      6'd16: n = {1'b0, e.csr_read}; // [R19]
      6'd17: n = {1'b0, e.csr_rw}; // [R19]
      6'd18: n = {1'b0, e.csr_write_rd0}; // [R19]
      6'd19: n = {1'b0, e.ebreak}; // [R19]
      6'd20: n = {1'b0, e.ecall}; // [R19]
      6'd21: n = {1'b0, e.fence}; // [R19]
      6'd22: n = {1'b0, e.fence_i}; // [R19]
      6'd23: n = {1'b0, e.mret}; // [R19]
      6'd24: n = {1'b0, e.br_commit}; // [R20]
      6'd25: n = {1'b0, e.br_mispredict}; // [R20]
      6'd26: n = {1'b0, e.br_taken}; // [R20]
      6'd27: n = {1'b0, e.br_unpredict}; // [R20]
      6'd28: n = {1'b0, e.stall_fetch}; // [R21]
      6'd29: n = {1'b0, e.stall_aligner}; // [R21]
      6'd30: n = {1'b0, e.stall_decode}; // [R21]
      6'd31: n = {1'b0, e.stall_postsync}; // [R21]
      6'd32: n = {1'b0, e.stall_presync}; // [R21]
      6'd33: n = {1'b0, e.loadstore_pipe_freeze}; // [R21]
      6'd34: n = {1'b0, e.store_and_write_buffers_full}; // [R21]
      6'd35: n = {1'b0, e.stall_dma_data}; // [R21]
      6'd36: n = {1'b0, e.stall_dma_instr}; // [R21]
      6'd37: n = {1'b0, e.exception}; // [R22]
      6'd38: n = {1'b0, e.timer_int}; // [R22]
      6'd39: n = {1'b0, e.ext_int}; // [R22]
      6'd40: n = {1'b0, e.trap_logic_unit_flush}; // [R22]
      6'd41: n = {1'b0, e.br_error_flush}; // [R22]
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  // Halt rules; pause leaves counting on, DMA stalls drop out with run
  always_comb begin
    run = !power_mgmt_halt_state && !(debug_halted_state && dbg_stopcount); // [R7] [R8] [R9] [R10]
  end

  assign count_permitted = run;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      inc[i] = (run && st.gpmc_en) ? evt_count(st.evt[i], events) : 2'h0; // [R1] [R5]
    end
  end

  always_comb begin
    logic [11:0] a;
    logic [31:0] rd;
    logic hit;
    a = csr_req.addr;
    rd = 32'h0;
    hit = 1'b0;
    next_st = st;
    // Increment first, so a same-cycle write overrides it
    for (int i = 0; i < 4; i++) begin
      next_st.cnt[i] = st.cnt[i] + {62'h0, inc[i]}; // [R24] [R11] [R2]
    end
    if (a == pmc_addr_gpmc) begin
      hit = 1'b1;
      rd = {31'h0, st.gpmc_en}; // [R3]
      if (csr_req.wr) next_st.gpmc_en = csr_req.wdata[0]; // [R1] [R4]
    end
    for (int i = 0; i < 4; i++) begin
      if (a == pmc_addr_cnt_lo + 12'(i)) begin
        hit = 1'b1;
        rd = st.cnt[i][31:0]; // [R11] [R23]
        if (csr_req.wr) next_st.cnt[i][31:0] = csr_req.wdata; // [R11]
      end
      if (a == pmc_addr_cnt_hi + 12'(i)) begin
        hit = 1'b1;
        rd = st.cnt[i][63:32]; // [R23]
        if (csr_req.wr) next_st.cnt[i][63:32] = csr_req.wdata;
      end
      if (a == pmc_addr_evt + 12'(i)) begin
        hit = 1'b1;
        rd = {26'h0, st.evt[i]};
        if (csr_req.wr) begin
          next_st.evt[i] = (csr_req.wdata > {26'h0, pmc_evt_max}) ? pmc_evt_max : csr_req.wdata[5:0]; // [R13] [R4]
        end
      end
    end
    // Unused counters and selectors 7..31 read zero
    if ((a[11:5] == pmc_addr_cnt_lo[11:5] || a[11:5] == pmc_addr_cnt_hi[11:5] || a[11:5] == pmc_addr_evt[11:5])
        && a[4:0] >= 5'd7 && a[4:0] <= pmc_addr_hpm_last[4:0]) begin
      hit = 1'b1;
      rd = 32'h0; // [R6]
    end
    next_st.rdata = (csr_req.rd || csr_req.wr) ? rd : 32'h0;
    csr_hit = hit && (csr_req.rd || csr_req.wr);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st.gpmc_en <= pmc_gpmc_reset; // [R1]
      st.cnt <= {4{pmc_cnt_reset}};
      st.evt <= {4{pmc_evt_reset}};
      st.rdata <= 32'h0;
    end else begin
      st <= next_st;
    end
  end

  assign csr_rdata = st.rdata;

  chk_group_gate: assert property (@(posedge clock) disable iff (!arst_n)
    !st.gpmc_en && !(csr_req.wr) |=> st.cnt == $past(st.cnt)) else $error("counter moved while disabled"); // [R1]
  chk_enable_keeps: assert property (@(posedge clock) disable iff (!arst_n)
    csr_req.wr && csr_req.addr == pmc_addr_gpmc && !st.gpmc_en |=> st.cnt[0] == $past(st.cnt[0]))
    else $error("enable write changed counter"); // [R2]
  chk_gpmc_read: assert property (@(posedge clock) disable iff (!arst_n)
    csr_req.rd && csr_req.addr == pmc_addr_gpmc |=> csr_rdata[31:1] == 31'h0) else $error("reserved bits nonzero"); // [R3]
  chk_evt_legal: assert property (@(posedge clock) disable iff (!arst_n)
    st.evt[0] <= pmc_evt_max && st.evt[3] <= pmc_evt_max) else $error("illegal selector"); // [R4]
  chk_evt_clamp: assert property (@(posedge clock) disable iff (!arst_n)
    csr_req.wr && csr_req.addr == pmc_addr_evt && csr_req.wdata > 32'd41 |=> st.evt[0] == pmc_evt_max)
    else $error("selector not clamped"); // [R13]
  chk_unused_zero: assert property (@(posedge clock) disable iff (!arst_n)
    csr_req.rd && csr_req.addr == pmc_addr_cnt_lo + 12'd7 |=> csr_rdata == 32'h0) else $error("unused counter nonzero"); // [R6]
  chk_halt_stop: assert property (@(posedge clock) disable iff (!arst_n)
    power_mgmt_halt_state && !csr_req.wr |=> st.cnt == $past(st.cnt)) else $error("count during halt"); // [R7]
  chk_dbg_stop: assert property (@(posedge clock) disable iff (!arst_n)
    debug_halted_state && dbg_stopcount |-> !count_permitted) else $error("count in debug halt"); // [R8]
  chk_cycle_evt: assert property (@(posedge clock) disable iff (!arst_n)
    st.evt[1] == 6'd1 && st.gpmc_en && count_permitted && !csr_req.wr |=> st.cnt[1] == $past(st.cnt[1]) + 64'h1)
    else $error("cycle event miscounted"); // [R14]
  chk_read_before: assert property (@(posedge clock) disable iff (!arst_n)
    csr_req.rd && !csr_req.wr && csr_req.addr == pmc_addr_cnt_lo |=> csr_rdata == $past(st.cnt[0][31:0]))
    else $error("read after increment"); // [R11]
  chk_pause_runs: assert property (@(posedge clock) disable iff (!arst_n)
    pause_active && !power_mgmt_halt_state && !(debug_halted_state && dbg_stopcount) |-> count_permitted) // [R10]
    else $error("pause stopped counting");
  chk_pm_halt_perm: assert property (@(posedge clock) disable iff (!arst_n)
    power_mgmt_halt_state |-> !count_permitted) else $error("counting allowed in halt"); // [R7]
  chk_write_wins: assert property (@(posedge clock) disable iff (!arst_n)
    csr_req.wr && csr_req.addr == pmc_addr_cnt_lo |=> st.cnt[0][31:0] == $past(csr_req.wdata))
    else $error("write lost to increment"); // [R11]
  cov_clamp: cover property (@(posedge clock) csr_req.wr && csr_req.addr == pmc_addr_evt && csr_req.wdata > 32'd41);
  cov_halt: cover property (@(posedge clock) power_mgmt_halt_state ##1 !power_mgmt_halt_state);
  cov_double: cover property (@(posedge clock) inc[0] == 2'h2);
  cov_write_cnt: cover property (@(posedge clock) csr_req.wr && csr_req.addr == pmc_addr_cnt_lo + 12'h1);
endmodule // pmc_unit

// file: verif/pmc_core_model.sv
// Core pipeline model raising one selected event indication
`timescale 1ns/1ns
module pmc_core_model (
  input wire logic [5:0] code,
  input wire logic fire,
  output pmc_pkg::pmc_events_t events
);
  import pmc_pkg::*;
  // Only the chosen field is raised, so a wrong decode reads zero
  always_comb begin
    int pos;
    logic [45:0] val;
    pos = 0;
    val = (code inside {[4:8], 15}) ? 46'h2 : 46'h1;
    for (int c = 41; c > int'(code); c--) begin
      pos += (c inside {[4:8], 15}) ? 2 : 1;
    end
    events = '0;
    if (fire && code > 6'h01) begin
      events = pmc_events_t'(val << pos);
    end
  end
endmodule // pmc_core_model

// file: verif/tb.sv
// Self-checking bench for the performance monitor counters
`timescale 1ns/1ns
module tb;
  import pmc_pkg::*;
  logic clock, arst_n, csr_hit, count_permitted, fire, h, p;
  logic power_mgmt_halt_state, debug_halted_state, dbg_stopcount, pause_active;
  logic [31:0] csr_rdata, q;
  logic [5:0] code;
  pmc_csr_req_t csr_req;
  pmc_events_t events;
  int err_total, compares, cyc;
  int inc_tab [42] = '{0, 1, 1, 1, 2, 2, 2, 2, 2, 1, 1, 1, 1, 1, 1, 2, 1, 1, 1, 1, 1,
    1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1};
  pmc_unit pmc_unit_i (.clock(clock), .arst_n(arst_n), .csr_req(csr_req), .csr_rdata(csr_rdata),
    .csr_hit(csr_hit), .events(events), .power_mgmt_halt_state(power_mgmt_halt_state),
    .debug_halted_state(debug_halted_state), .dbg_stopcount(dbg_stopcount),
    .pause_active(pause_active), .count_permitted(count_permitted));
  pmc_core_model pmc_core_model_i (.code(code), .fire(fire), .events(events));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    #1;
    csr_req = '{rd: !w, wr: w, addr: a, wdata: d};
    #1;
    h = csr_hit;
    @(posedge clock);
    #1;
    q = csr_rdata;
    csr_req = '0;
  endtask
  // Opens exactly n counting cycles
  task automatic run(input int n);
    @(posedge clock);
    #1;
    power_mgmt_halt_state = 0;
    fire = 1;
    repeat (n) @(posedge clock);
    #1;
    p = count_permitted;
    power_mgmt_halt_state = 1;
    fire = 0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    csr_req = '0;
    fire = 0;
    code = 0;
    arst_n = 0;
    power_mgmt_halt_state = 1;
    debug_halted_state = 0;
    dbg_stopcount = 0;
    pause_active = 0;
    repeat (4) @(posedge clock);
    #1;
    arst_n = 1;
    csr(0, pmc_addr_gpmc, 0);
    chk("gpmc_reset", 1, q);
    chk("gpmc_hit", 1, 32'(h));
    csr(0, pmc_addr_cnt_hi, 0);
    chk("cnt_reset", 0, q);
    csr(1, pmc_addr_gpmc, '1);
    csr(0, pmc_addr_gpmc, 0);
    chk("gpmc_legal", 1, q);
    $display("test reset_regs done");
    foreach (inc_tab[c]) begin
      code = 6'(c);
      csr(1, pmc_addr_evt + 12'(c % 4), 32'(c));
      csr(1, pmc_addr_cnt_lo + 12'(c % 4), 0);
      run(3);
      csr(0, pmc_addr_cnt_lo + 12'(c % 4), 0);
      chk("evt_count", 32'(3 * inc_tab[c]), q);
    end
    $display("test event_table done");
    csr(1, pmc_addr_gpmc, 0);
    csr(1, pmc_addr_cnt_lo, 7);
    code = 2;
    csr(1, pmc_addr_evt, 2);
    run(4);
    csr(1, pmc_addr_gpmc, 1);
    csr(0, pmc_addr_cnt_lo, 0);
    chk("gated_hold", 7, q);
    csr(1, pmc_addr_evt, 32'h12345678);
    csr(0, pmc_addr_evt, 0);
    chk("evt_clamp", 32'(pmc_evt_max), q);
    csr(1, pmc_addr_cnt_lo + 12'h4, '1);
    csr(0, pmc_addr_cnt_lo + 12'h4, 0);
    chk("unused_cnt", 0, q);
    csr(0, 12'h123, 0);
    chk("unmapped_hit", 0, 32'(h));
    $display("test gating done");
    code = 35;
    csr(1, pmc_addr_evt, 35);
    csr(1, pmc_addr_cnt_lo, 0);
    csr(1, pmc_addr_evt + 12'h1, 1);
    csr(1, pmc_addr_cnt_lo + 12'h1, 0);
    debug_halted_state = 1;
    dbg_stopcount = 1;
    run(3);
    chk("perm_stop", 0, 32'(p));
    csr(0, pmc_addr_cnt_lo, 0);
    chk("dma_halted", 0, q);
    dbg_stopcount = 0;
    pause_active = 1;
    run(3);
    csr(0, pmc_addr_cnt_lo + 12'h1, 0);
    chk("dbg_run", 3, q);
    csr(1, pmc_addr_cnt_lo + 12'h1, '1);
    run(2);
    csr(0, pmc_addr_cnt_hi + 12'h1, 0);
    chk("carry_hi", 1, q);
    csr(1, pmc_addr_cnt_lo + 12'h1, 5);
    @(posedge clock);
    #1;
    power_mgmt_halt_state = 0;
    csr_req = '{rd: 1'b1, wr: 1'b0, addr: pmc_addr_cnt_lo + 12'h1, wdata: 32'h0};
    @(posedge clock);
    #1;
    chk("read_before_inc", 5, csr_rdata);
    csr_req = '{rd: 1'b0, wr: 1'b1, addr: pmc_addr_cnt_lo + 12'h1, wdata: 32'h100};
    @(posedge clock);
    #1;
    power_mgmt_halt_state = 1;
    csr_req = '0;
    csr(0, pmc_addr_cnt_lo + 12'h1, 0);
    chk("write_after_inc", 32'h100, q);
    $display("test halt_order done");
    @(posedge clock);
    #1;
    arst_n = 0;
    repeat (2) @(posedge clock);
    #1;
    arst_n = 1;
    csr(0, pmc_addr_cnt_hi + 12'h1, 0);
    chk("rerun_cnt", 0, q);
    csr(0, pmc_addr_evt + 12'h1, 0);
    chk("rerun_evt", 0, q);
    csr(0, pmc_addr_gpmc, 0);
    chk("rerun_gpmc", 1, q);
    $display("test mid_reset done");
    complete_run();
  end
endmodule // tb
